// >>> include/smsd_pkg.sv
// Shared types and constants of the serial controller
package smsd_pkg;
	localparam int DATA_W = 8;
	localparam int BIT_LAST_EDGE = 15;
	localparam logic [7:0] DMA_TX_BASE = 8'h80;
	localparam logic [7:0] DMA_RX_BASE = 8'hC0;
	localparam int DMA_MAX_BYTES = 64;
	localparam int RAM_AW = 7;
	localparam int DIR_BIT_P3 = 3;
	localparam int DIR_BIT_P4 = 4;
	localparam int DMA_CNT_LSB = 2;
	localparam int DMA_GAP_W = 2;
	localparam int GAP_UNIT_CYC = 32;
	localparam int GAP_CNT_W = 7;
	localparam int DIV_W = 5;
	localparam int HALF_MIN_CYC = 4;
	localparam int SYNC_W = 2;

	typedef enum logic [1:0] {
		SMSD_IDLE = 2'b00,
		SMSD_FETCH = 2'b01,
		SMSD_SHIFT = 2'b10,
		SMSD_GAP = 2'b11
	} smsd_state_type;

	typedef struct packed {
		logic enable;
		logic master;
		logic cpol;
		logic cpha;
		logic lsb_first;
		logic [1:0] rate;
		logic ssdis;
		logic dma_en;
		logic single_data_pin_mode;
	} smsd_cfg_type;

	typedef struct packed {
		logic spif;
		logic modf;
		logic wcol;
	} smsd_flags_type;

	typedef struct packed {
		logic we;
		logic re;
		logic [RAM_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} smsd_ram_req_type;
endpackage : smsd_pkg

// >>> rtl/smsd_dma_ram.sv
// Buffer RAM shared by the processor and the DMA engine
`timescale 1ns/100ps
module smsd_dma_ram #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic mclk_i,
	input wire logic cpu_we_i,
	input wire logic [AW-1:0] cpu_addr_i,
	input wire logic [DW-1:0] cpu_wdata_i,
	output logic [DW-1:0] cpu_rdata_o,
	input wire logic dma_we_i,
	input wire logic dma_re_i,
	input wire logic [AW-1:0] dma_addr_i,
	input wire logic [DW-1:0] dma_wdata_i,
	output logic [DW-1:0] dma_rdata_o
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] cpu_rd_q;
	logic [DW-1:0] dma_rd_q;

	// Same-address writes: the engine wins, it owns the buffer mid burst
	always_ff @(posedge mclk_i) begin
		if (cpu_we_i && !(dma_we_i && dma_addr_i == cpu_addr_i)) begin
			mem_q[cpu_addr_i] <= cpu_wdata_i;
		end
		if (dma_we_i) begin
			mem_q[dma_addr_i] <= dma_wdata_i;
		end
		cpu_rd_q <= mem_q[cpu_addr_i];
		if (dma_re_i) begin
			dma_rd_q <= mem_q[dma_addr_i];
		end
	end

	assign cpu_rdata_o = cpu_rd_q;
	assign dma_rdata_o = dma_rd_q;
endmodule : smsd_dma_ram

// >>> rtl/smsd_core.sv
// Serial master/slave controller with DMA burst and single data pin mode
// Operation
// - Master idles until data register write, then starts the transfer at once.
// - Master launches each bit on launch edge, the first at load when phase clear; samples slave on capture edge.
// - Phase clear: slave shows first bit before first clock edge.
// - Phase set: slave also shows first bit before first clock edge.
// - Hardware sets transfer-complete at end; it requests an interrupt.
// - Mode fault set when master, select low and select-disable clear.
// - Interrupt request stands while either flag is set.
// - DMA sends from RAM 0x00-0x3F and stores into RAM 0x40-0x7F.
// - DMA: data bits 7:2 give byte count minus one, bits 1:0 the gap.
// - A burst moves at most 64 bytes; complete flag set at end.
// - Master DMA drives select out when select-disable bit is one.
// - Single data pin mode exchanges data over one pin.
// - Shared pin: pin three as master, pin four as slave, by direction.
// - In single pin mode the unused pin is released.
// - Master offers four serial clock rates.
// - Clock polarity and phase are software selectable.
// - Words are 8 bits, MSB or LSB first by software choice.
// - Write during a transfer sets write-collision, shifting byte kept.
`timescale 1ns/100ps
module smsd_core #(
	parameter int GAP_UNIT = smsd_pkg::GAP_UNIT_CYC
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic sclk_link_i,
	input wire smsd_pkg::smsd_cfg_type cfg_i,
	input wire logic [7:0] port_direction_reg_i,
	input wire logic dat_wr_i,
	input wire logic [7:0] dat_wdata_i,
	input wire logic clr_spif_i,
	input wire logic clr_modf_i,
	input wire logic clr_wcol_i,
	input wire logic cpu_ram_we_i,
	input wire logic [6:0] cpu_ram_addr_i,
	input wire logic [7:0] cpu_ram_wdata_i,
	output logic [7:0] cpu_ram_rdata_o,
	output logic [7:0] serial_data_reg_o,
	output smsd_pkg::smsd_flags_type flags_o,
	output logic irq_o,
	output logic busy_o,
	input wire logic ssn_i,
	output logic ssn_o,
	output logic ssn_oe_o,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic port_pin_three_i,
	output logic port_pin_three_o,
	output logic port_pin_three_oe_o,
	input wire logic port_pin_four_i,
	output logic port_pin_four_o,
	output logic port_pin_four_oe_o,
	output logic pin_three_free_o,
	output logic pin_four_free_o
);
	typedef struct packed {
		smsd_pkg::smsd_state_type st;
		logic [smsd_pkg::DIV_W-1:0] div;
		logic [3:0] edge_n;
		logic [7:0] sh;
		logic [7:0] rx;
		logic mosi;
		logic sck;
		logic [5:0] last_idx;
		logic [5:0] idx;
		logic [smsd_pkg::DMA_GAP_W-1:0] gap;
		logic [smsd_pkg::GAP_CNT_W-1:0] gcnt;
		logic dma;
		smsd_pkg::smsd_flags_type fl;
		logic irq;
		logic [7:0] rxdat;
		logic [7:0] txhold;
		logic ssn_out;
		logic ssn_oe;
		logic sck_oe;
		logic p3_oe;
		logic p4_oe;
		logic p3_free;
		logic p4_free;
		logic [smsd_pkg::SYNC_W-1:0] ssn_s;
		logic [smsd_pkg::SYNC_W-1:0] p3_s;
		logic [smsd_pkg::SYNC_W-1:0] p4_s;
		logic [2:0] tgl_s;
	} smsd_main_type;

	typedef struct packed {
		logic [2:0] cnt;
		logic [7:0] rx;
		logic [7:0] done;
		logic tgl;
	} smsd_link_type;

	smsd_main_type q, d;
	smsd_link_type lq, ld;
	smsd_pkg::smsd_ram_req_type ram;
	logic [7:0] ram_rdata;
	logic lclk;
	logic link_in;

	function automatic logic [7:0] smsd_order(input logic [7:0] v,
		input logic lsb);
		logic [7:0] r;
		r = v;
		if (lsb) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = v[7-i];
			end
		end
		return r;
	endfunction : smsd_order

	function automatic logic [smsd_pkg::DIV_W-1:0] smsd_half(
		input logic [1:0] rate);
		// Last count of a 4 to 32 cycle half: synchroniser must fit
		return smsd_pkg::DIV_W'((smsd_pkg::HALF_MIN_CYC << rate) - 1);
	endfunction : smsd_half

	smsd_dma_ram #(
		.AW(smsd_pkg::RAM_AW),
		.DW(smsd_pkg::DATA_W)
	) u_ram (
		.mclk_i(mclk_i),
		.cpu_we_i(cpu_ram_we_i),
		.cpu_addr_i(cpu_ram_addr_i),
		.cpu_wdata_i(cpu_ram_wdata_i),
		.cpu_rdata_o(cpu_ram_rdata_o),
		.dma_we_i(ram.we),
		.dma_re_i(ram.re),
		.dma_addr_i(ram.addr),
		.dma_wdata_i(ram.wdata),
		.dma_rdata_o(ram_rdata)
	);

	// Slave side on the external clock; capture edge made the rising one
	assign lclk = sclk_link_i ^ cfg_i.cpol ^ cfg_i.cpha;
	assign link_in = cfg_i.single_data_pin_mode ? port_pin_four_i
		: port_pin_three_i;

	always_comb begin
		ld = lq;
		if (!ssn_i) begin
			ld.rx = {lq.rx[6:0], link_in};
			ld.cnt = lq.cnt + 3'h1;
			if (lq.cnt == 3'h7) begin
				ld.done = {lq.rx[6:0], link_in};
				ld.tgl = ~lq.tgl;
			end
		end
	end

	// Reset only lands on a link edge; the external clock may stand still
	always_ff @(posedge lclk) begin
		if (!resetn_i) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	always_comb begin
		logic tick;
		logic lead;
		logic cap;
		logic launch;
		logic in_bit;
		logic [7:0] rx_new;
		logic wr_master;
		tick = 1'b0;
		lead = 1'b0;
		cap = 1'b0;
		launch = 1'b0;
		in_bit = 1'b0;
		rx_new = q.rx;
		wr_master = dat_wr_i && cfg_i.enable && cfg_i.master;
		d = q;
		ram = '0;
		d.ssn_s = {q.ssn_s[0], ssn_i};
		d.p3_s = {q.p3_s[0], port_pin_three_i};
		d.p4_s = {q.p4_s[0], port_pin_four_i};
		d.tgl_s = {q.tgl_s[1:0], lq.tgl};
		in_bit = cfg_i.single_data_pin_mode ? q.p3_s[1] : q.p4_s[1];
		if (clr_spif_i) begin
			d.fl.spif = 1'b0;
		end
		if (clr_modf_i) begin
			d.fl.modf = 1'b0;
		end
		if (clr_wcol_i) begin
			d.fl.wcol = 1'b0;
		end
		if (cfg_i.enable && cfg_i.master && !q.ssn_s[1] && !cfg_i.ssdis
			&& !q.ssn_oe) begin
			d.fl.modf = 1'b1;
		end
		// Slave byte done, seen through the toggle crossing
		if (!cfg_i.master && (q.tgl_s[2] != q.tgl_s[1])) begin
			d.fl.spif = 1'b1;
			d.rxdat = smsd_order(lq.done, cfg_i.lsb_first);
		end
		if (dat_wr_i && cfg_i.enable && !cfg_i.master) begin
			if (!q.ssn_s[1]) begin
				d.fl.wcol = 1'b1;
			end else begin
				d.txhold = smsd_order(dat_wdata_i, cfg_i.lsb_first);
			end
		end
		if (wr_master && q.st != smsd_pkg::SMSD_IDLE) begin
			d.fl.wcol = 1'b1;
		end
		case (q.st)
			smsd_pkg::SMSD_IDLE: begin
				d.sck = cfg_i.cpol;
				if (wr_master) begin
					d.dma = cfg_i.dma_en;
					d.idx = '0;
					if (cfg_i.dma_en) begin
						d.last_idx = dat_wdata_i[7:smsd_pkg::DMA_CNT_LSB];
						d.gap = dat_wdata_i[smsd_pkg::DMA_GAP_W-1:0];
						d.ssn_oe = cfg_i.ssdis;
						d.ssn_out = 1'b0;
						ram.re = 1'b1;
						ram.addr = smsd_pkg::DMA_TX_BASE[6:0];
						d.st = smsd_pkg::SMSD_FETCH;
					end else begin
						d.sh = smsd_order(dat_wdata_i, cfg_i.lsb_first);
						d.st = smsd_pkg::SMSD_SHIFT;
					end
				end
			end
			smsd_pkg::SMSD_FETCH: begin
				d.sh = smsd_order(ram_rdata, cfg_i.lsb_first);
				d.st = smsd_pkg::SMSD_SHIFT;
			end
			smsd_pkg::SMSD_SHIFT: begin
				d.div = q.div + smsd_pkg::DIV_W'(1);
				if (q.div == smsd_half(cfg_i.rate)) begin
					tick = 1'b1;
					d.div = '0;
				end
				lead = !q.edge_n[0];
				cap = tick && (lead ^ cfg_i.cpha);
				launch = tick && (cfg_i.cpha ? lead
					: (!lead && q.edge_n != 4'(smsd_pkg::BIT_LAST_EDGE)));
				if (cap) begin
					rx_new = {q.rx[6:0], in_bit};
					d.rx = rx_new;
				end
				if (launch) begin
					d.mosi = q.sh[7];
					d.sh = {q.sh[6:0], 1'b0};
				end
				if (tick) begin
					d.sck = ~q.sck;
					d.edge_n = q.edge_n + 4'h1;
				end
				if (tick && q.edge_n == 4'(smsd_pkg::BIT_LAST_EDGE)) begin
					d.edge_n = '0;
					d.rxdat = smsd_order(rx_new, cfg_i.lsb_first);
					if (q.dma) begin
						ram.we = 1'b1;
						ram.addr = smsd_pkg::DMA_RX_BASE[6:0] | 7'(q.idx);
						ram.wdata = d.rxdat;
					end
					if (!q.dma || q.idx == q.last_idx) begin
						d.fl.spif = 1'b1;
						d.ssn_oe = 1'b0;
						d.ssn_out = 1'b1;
						d.st = smsd_pkg::SMSD_IDLE;
					end else begin
						d.idx = q.idx + 6'h1;
						d.gcnt = smsd_pkg::GAP_CNT_W'(q.gap * GAP_UNIT);
						d.st = smsd_pkg::SMSD_GAP;
					end
				end
			end
			smsd_pkg::SMSD_GAP: begin
				d.gcnt = q.gcnt - smsd_pkg::GAP_CNT_W'(1);
				if (q.gcnt == '0) begin
					ram.re = 1'b1;
					ram.addr = smsd_pkg::DMA_TX_BASE[6:0] | 7'(q.idx);
					d.st = smsd_pkg::SMSD_FETCH;
				end
			end
			default: begin
				d.st = smsd_pkg::SMSD_IDLE;
			end
		endcase
		// Phase 0 presents the first bit as the byte is loaded
		if (d.st == smsd_pkg::SMSD_SHIFT && q.st != smsd_pkg::SMSD_SHIFT) begin
			d.div = '0;
			d.edge_n = '0;
			if (!cfg_i.cpha) begin
				d.mosi = d.sh[7];
				d.sh = {d.sh[6:0], 1'b0};
			end
		end
		d.irq = d.fl.spif | d.fl.modf;
		d.sck_oe = cfg_i.enable && cfg_i.master;
		d.p3_oe = cfg_i.enable && cfg_i.master && (!cfg_i.single_data_pin_mode
			|| port_direction_reg_i[smsd_pkg::DIR_BIT_P3]);
		d.p4_oe = cfg_i.enable && !cfg_i.master && !q.ssn_s[1]
			&& (!cfg_i.single_data_pin_mode
			|| port_direction_reg_i[smsd_pkg::DIR_BIT_P4]);
		d.p3_free = !cfg_i.enable || (cfg_i.single_data_pin_mode
			&& !cfg_i.master);
		d.p4_free = !cfg_i.enable || (cfg_i.single_data_pin_mode
			&& cfg_i.master);
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.ssn_out <= 1'b1;
			q.ssn_s <= '1;
			q.st <= smsd_pkg::SMSD_IDLE;
		end else begin
			q <= d;
		end
	end

	assign serial_data_reg_o = q.rxdat;
	assign flags_o = q.fl;
	assign irq_o = q.irq;
	assign busy_o = (q.st != smsd_pkg::SMSD_IDLE);
	assign ssn_o = q.ssn_out;
	assign ssn_oe_o = q.ssn_oe;
	assign sck_o = q.sck;
	assign sck_oe_o = q.sck_oe;
	assign port_pin_three_o = q.mosi;
	assign port_pin_three_oe_o = q.p3_oe;
	// Bit index from the link counter; the slave byte is held still while selected
	assign port_pin_four_o = q.txhold[3'h7 - lq.cnt];
	assign port_pin_four_oe_o = q.p4_oe;
	assign pin_three_free_o = q.p3_free;
	assign pin_four_free_o = q.p4_free;
endmodule : smsd_core

// >>> sim/smsd_core_assertions.sv
// Port checker of the serial controller
`timescale 1ns/100ps
module smsd_core_assertions (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire smsd_pkg::smsd_cfg_type cfg_i,
	input wire logic dat_wr_i,
	input wire logic ssn_i,
	input wire smsd_pkg::smsd_flags_type flags_o,
	input wire logic irq_o,
	input wire logic busy_o,
	input wire logic ssn_o,
	input wire logic ssn_oe_o,
	input wire logic pin_four_free_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_go;
		dat_wr_i && cfg_i.enable && cfg_i.master && !busy_o;
	endsequence
	sequence s_fault;
		(cfg_i.enable && cfg_i.master && !cfg_i.ssdis && !ssn_i) [*3];
	endsequence
	chk_start_on_write: assert property (s_go |=> busy_o)
		else $error("transfer did not start on write");
	chk_wcol_when_busy: assert property (
		dat_wr_i && busy_o |=> flags_o.wcol)
		else $error("write during transfer left no collision");
	chk_spif_at_end: assert property (
		$fell(busy_o) |-> ##[0:3] flags_o.spif)
		else $error("transfer ended without complete flag");
	chk_modf_on_select: assert property (
		s_fault |=> ##[0:2] flags_o.modf)
		else $error("select low in master role gave no fault");
	chk_irq_raised: assert property (
		flags_o.spif || flags_o.modf |-> ##[0:1] irq_o)
		else $error("flag set without interrupt");
	chk_irq_removed: assert property (
		(!flags_o.spif && !flags_o.modf) [*2] |-> !irq_o)
		else $error("interrupt with both flags clear");
	chk_ssn_burst: assert property (
		busy_o && $past(busy_o) && cfg_i.dma_en && cfg_i.ssdis
		&& cfg_i.master |-> ssn_oe_o && !ssn_o)
		else $error("select not driven during burst");
	chk_pin_release: assert property (
		(cfg_i.enable && cfg_i.master && cfg_i.single_data_pin_mode) [*2]
		|-> pin_four_free_o)
		else $error("unused pin not released");
endmodule : smsd_core_assertions
bind smsd_core smsd_core_assertions smsd_core_assertions_i (.mclk_i,
	.resetn_i, .cfg_i, .dat_wr_i, .ssn_i, .flags_o, .irq_o, .busy_o,
	.ssn_o, .ssn_oe_o, .pin_four_free_o);

// >>> sim/smsd_far_slave.sv
// External shift register slave that echoes the last byte it took
`timescale 1ns/100ps
module smsd_far_slave #(
	parameter logic [7:0] INIT = 8'h3C
) (
	input wire logic sck_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic [7:0] rx_o
);
	logic [7:0] tx = INIT;
	logic [2:0] n = 3'h0;
	logic o = INIT[7];
	wire logic e = sck_i ^ cpol_i ^ cpha_i;
	initial rx_o = INIT;
	always @(posedge e) if (!sel_n_i) begin
		rx_o <= {rx_o[6:0], mosi_i};
		n <= n + 3'h1;
		if (n == 3'h7) tx <= {rx_o[6:0], mosi_i};
	end
	always @(negedge e) if (!sel_n_i) o <= tx[3'h7 - n];
	always @(negedge sel_n_i) o <= tx[3'h7 - n];
	// Deselected line floats: show the inverse, not a stale bit
	assign miso_o = sel_n_i ? ~o : o;
endmodule : smsd_far_slave

// >>> sim/smsd_core_test.sv
// Self-checking bench of the serial controller
`timescale 1ns/100ps
module smsd_core_test;
	logic mclk_i = 1'h0, resetn_i = 1'h0, sclk_link_i = 1'h0;
	logic dat_wr_i = 1'h0, clr_spif_i = 1'h0, clr_modf_i = 1'h0;
	logic clr_wcol_i = 1'h0, cpu_ram_we_i = 1'h0, ssn_drv_n = 1'h1;
	logic sel_n = 1'h1, port_pin_three_i = 1'h0, port_pin_four_i;
	logic [6:0] cpu_ram_addr_i = 7'h00;
	logic [7:0] dat_wdata_i = 8'h00, cpu_ram_wdata_i = 8'h00;
	logic [7:0] port_direction_reg_i = 8'h18, w = 8'h3C, e, rxm;
	logic [7:0] cpu_ram_rdata_o, serial_data_reg_o, sd = 8'h96, st = 8'hC3;
	logic [7:0] pat [4] = '{8'hA5, 8'h01, 8'h80, 8'h5E};
	logic irq_o, busy_o, ssn_o, ssn_oe_o, sck_o, port_pin_three_o;
	logic port_pin_four_o, pin_four_free_o;
	smsd_pkg::smsd_cfg_type cfg_i = 10'h000;
	smsd_pkg::smsd_flags_type flags_o;
	int n_fail = 0, comparisons = 0;
	wire logic ssn_i = ssn_oe_o ? ssn_o : ssn_drv_n;
	smsd_core #(.GAP_UNIT(1)) smsd_core_i (.mclk_i, .resetn_i,
		.sclk_link_i, .cfg_i, .port_direction_reg_i, .dat_wr_i,
		.dat_wdata_i, .clr_spif_i, .clr_modf_i, .clr_wcol_i, .cpu_ram_we_i,
		.cpu_ram_addr_i, .cpu_ram_wdata_i, .cpu_ram_rdata_o,
		.serial_data_reg_o, .flags_o, .irq_o, .busy_o, .ssn_i, .ssn_o,
		.ssn_oe_o, .sck_o, .sck_oe_o(), .port_pin_three_i,
		.port_pin_three_o, .port_pin_three_oe_o(), .port_pin_four_i,
		.port_pin_four_o, .port_pin_four_oe_o(), .pin_three_free_o(),
		.pin_four_free_o);
	smsd_far_slave #(.INIT(8'h3C)) smsd_far_slave_i (.sck_i(sck_o),
		.cpol_i(cfg_i.cpol), .cpha_i(cfg_i.cpha), .sel_n_i(sel_n),
		.mosi_i(port_pin_three_o), .miso_o(port_pin_four_i), .rx_o(rxm));
	always #12.5 mclk_i = ~mclk_i;
	task tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask : tick
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] d);
		dat_wdata_i = d;
		dat_wr_i = 1'h1;
		tick(1);
		dat_wr_i = 1'h0;
	endtask : wr
	task clr();
		{clr_spif_i, clr_modf_i, clr_wcol_i} = 3'h7;
		tick(1);
		{clr_spif_i, clr_modf_i, clr_wcol_i} = 3'h0;
		tick(2);
	endtask : clr
	task wait_spif();
		for (int i = 0; i < 4000 && flags_o.spif !== 1'h1; i++) tick(1);
		chk({7'h00, flags_o.spif}, 8'h01);
	endtask : wait_spif
	task ram_wr(input logic [6:0] a, input logic [7:0] d);
		cpu_ram_addr_i = a;
		cpu_ram_wdata_i = d;
		cpu_ram_we_i = 1'h1;
		tick(1);
		cpu_ram_we_i = 1'h0;
	endtask : ram_wr
	task ram_rd(input logic [6:0] a, input logic [7:0] x);
		cpu_ram_addr_i = a;
		tick(2);
		chk(cpu_ram_rdata_o, x);
	endtask : ram_rd
	function automatic logic [7:0] rev(input logic [7:0] b);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = b[7-i];
		return r;
	endfunction : rev
	// Link clock of 160 ns, only within the frame
	task frame(input logic [7:0] s, input logic [7:0] t);
		for (int i = 7; i >= 0; i--) begin
			sclk_link_i = cfg_i.cpol ^ cfg_i.cpha;
			port_pin_three_i = s[i];
			#20 chk({7'h00, port_pin_four_o}, {7'h00, t[i]});
			#60 sclk_link_i = ~sclk_link_i;
			#80;
		end
		sclk_link_i = cfg_i.cpol;
		port_pin_three_i = ~port_pin_three_i;
	endtask : frame
	task test_done();
		$display("errors %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// Link logic resets only on its own edge
	initial begin
		#40 sclk_link_i = 1'h1;
		#80 sclk_link_i = 1'h0;
	end
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
	initial begin
		tick(6);
		resetn_i = 1'h1;
		tick(2);
		cfg_i.enable = 1'h1;
		cfg_i.master = 1'h1;
		for (int m = 0; m < 4; m++) begin
			sel_n = 1'h1;
			{cfg_i.cpol, cfg_i.cpha} = 2'(m);
			cfg_i.rate = 2'(m);
			cfg_i.lsb_first = m[0];
			tick(3);
			sel_n = 1'h0;
			e = cfg_i.lsb_first ? rev(w) : w;
			wr(pat[m]);
			if (m == 3) begin
				tick(1);
				wr(8'hFF);
			end
			wait_spif();
			chk(serial_data_reg_o, e);
			w = cfg_i.lsb_first ? rev(pat[m]) : pat[m];
			chk(rxm, w);
			chk({7'h00, irq_o}, 8'h01);
			if (m == 3) chk({7'h00, flags_o.wcol}, 8'h01);
			clr();
			chk({7'h00, irq_o}, 8'h00);
		end
		ssn_drv_n = 1'h0;
		tick(5);
		chk({7'h00, flags_o.modf}, 8'h01);
		chk({7'h00, irq_o}, 8'h01);
		ssn_drv_n = 1'h1;
		tick(3);
		clr();
		chk({7'h00, irq_o}, 8'h00);
		sel_n = 1'h1;
		{cfg_i.dma_en, cfg_i.ssdis, cfg_i.cpol, cfg_i.cpha} = 4'hC;
		{cfg_i.lsb_first, cfg_i.rate} = 3'h0;
		tick(3);
		sel_n = 1'h0;
		ram_wr(7'h00, 8'h11);
		ram_wr(7'h01, 8'h22);
		wr(8'h04);
		wait_spif();
		ram_rd(7'h40, w);
		ram_rd(7'h41, 8'h11);
		chk(rxm, 8'h22);
		clr();
		sel_n = 1'h1;
		{cfg_i.dma_en, cfg_i.ssdis, cfg_i.master} = 3'h0;
		tick(3);
		wr(st);
		ssn_drv_n = 1'h0;
		tick(4);
		frame(sd, st);
		tick(2);
		ssn_drv_n = 1'h1;
		wait_spif();
		chk(serial_data_reg_o, sd);
		clr();
		// Phase set, idle high, LSB first
		{cfg_i.cpol, cfg_i.cpha, cfg_i.lsb_first} = 3'h7;
		sclk_link_i = 1'h1;
		tick(3);
		wr(8'hB4);
		ssn_drv_n = 1'h0;
		tick(4);
		frame(rev(8'h1E), rev(8'hB4));
		tick(2);
		ssn_drv_n = 1'h1;
		wait_spif();
		chk(serial_data_reg_o, 8'h1E);
		clr();
		cfg_i.master = 1'h1;
		cfg_i.single_data_pin_mode = 1'h1;
		tick(3);
		chk({7'h00, pin_four_free_o}, 8'h01);
		test_done();
	end
endmodule : smsd_core_test
